// ---- pms_regs.svh ----
/*
 register offsets, field positions and reset values of the power mode
 sequencer. assumes it is included by bare name where needed.
*/
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define PMS_PLL_CONTROL_REGISTER_OFS   8'h00
`define PMS_REG_CTL_OFS   8'h04
`define PMS_MODE_REQ_OFS  8'h08
`define PMS_STATUS_OFS    8'h0C

// ------------------------------------------------------------
// pll_control_register fields
// ------------------------------------------------------------
`define PMS_PLL_OFF_BIT   0
`define PMS_PLL_BYP_BIT   1
`define PMS_PLL_RST       2'h0

// ------------------------------------------------------------
// regulator_control_register fields
// ------------------------------------------------------------
`define PMS_REGULATOR_FREQUENCY_FIELD_LSB      0
`define PMS_WEN_PHY_BIT   2
`define PMS_WEN_RTC_BIT   3
`define PMS_WEN_ETH_BIT   4
`define PMS_SELFREF_BIT   5
`define PMS_REG_RST       6'h03

// ------------------------------------------------------------
// mode request codes written to the mode request register
// ------------------------------------------------------------
`define PMS_REQ_FULLON    3'h0
`define PMS_REQ_ACTIVE    3'h1
`define PMS_REQ_SLEEP     3'h2
`define PMS_REQ_DEEP      3'h3

`endif

// ---- pms_pkg.sv ----
/*
 types of the power mode sequencer. assumes nothing of its surroundings.
*/
`default_nettype none
package pms_pkg;
    // one-hot operating modes
    typedef enum logic [4:0] {
        PMS_FULLON = 5'h01,
        PMS_ACTIVE = 5'h02,
        PMS_SLEEP  = 5'h04,
        PMS_DEEP   = 5'h08,
        PMS_HIBER  = 5'h10
    } pms_mode_t;
endpackage
`default_nettype wire

// ---- pms_sequencer.sv ----
/*
 power mode sequencer: walks full-on, active, sleep, deep sleep and
 hibernate, gates core and system clocks, drives the regulator wake
 output and the pad three-state, and holds sdram in self-refresh.
 assumes one 100 MHz clock, a plain register port, and that rst here
 is the always-on domain reset; the chip reset pin arrives as rst_pin.
*/
// The register offsets and strobed register access were chosen for this implementation.
// Summary of operation
// - sleep stops core clock only
// - sleep wake picks mode from bypass flag; a rst_pin wake enters full-on
// - sleep blocks system dma to l1
// - deep sleep stops core and system clocks
// - deep sleep blocks async peripheral access
// - deep sleep exits only on reset, rtc
// - rtc wake from deep sleep enters active
// - reset in deep sleep enters full-on
// - hibernate removes core supply and clocks
// - frequency field zero drops wake output
// - hibernate three-states external signals
// - rtc or reset pin wake hibernate
// - hibernate wake starts hardware reset sequence
// - each wake source has enable bit; here the bits gate hibernate wake only, rst_pin has none
// - enabled wake event raises wake output
// - ethernet may request regulator power-up
// - only regulator register survives hibernate; here the mode request code req_q is kept too
// - control bit holds sdram in self-refresh
`timescale 1ns/100ps
`default_nettype none
`include "pms_regs.svh"

module pms_sequencer
(
    input  wire logic       clk,              // 100 MHz always-on clock
    input  wire logic       rst,              // async, active high
    input  wire logic [7:0] addr,             // register byte address
    input  wire logic [7:0] wdata,            // write data
    input  wire logic       wr,               // write strobe
    input  wire logic       rd,               // read strobe
    output var  logic [7:0] rdata,            // read data, cycle after rd
    input  wire logic       wake_pin_n,       // phy_interrupt_input pin
    input  wire logic       rtc_wake,         // rtc wakeup event level
    input  wire logic       rst_pin,          // chip reset pin, active high
    input  wire logic       eth_wake,         // ethernet wake request
    input  wire logic       core_idle,        // core executed idle
    output var  logic       core_clock_en,    // core_clock gate
    output var  logic       sys_clock_en,     // system clock gate
    output var  logic       core_power_en,    // core supply request
    output var  logic       regulator_wake_output,
    output var  logic       pads_hiz,         // three-state external pins
    output var  logic       l1_dma_block,     // refuse dma to l1
    output var  logic       async_block,      // refuse async accesses
    output var  logic       hw_reset_start,   // one-cycle reset kick
    output var  logic       sdram_self_refresh_hold,
    output var  logic [4:0] mode              // current mode, one-hot
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_q;                      // first stage, read by sync2
    logic [2:0] sync2_q;                      // second stage
    logic       rtc_prev_q;                   // for rtc edge detect

    // pins come from outside the clock domain
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
        end
        else
        begin
            sync1_q <= {rst_pin, rtc_wake, wake_pin_n};
            sync2_q <= sync1_q;
        end
    end

    wire logic phy_n_s = sync2_q[0];           // low means wake
    wire logic rtc_s   = sync2_q[1];
    wire logic rpin_s  = sync2_q[2];

    // rtc acts on the rising edge so a stale level does not re-wake
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rtc_prev_q <= 1'b0;
        else
            rtc_prev_q <= rtc_s;
    end
    wire logic rtc_ev = rtc_s & ~rtc_prev_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] pll_q;                        // pll_control_register
    logic [5:0] vr_q;                         // regulator_control_register
    logic       wake_q;                       // regulator wake level
    pms_pkg::pms_mode_t mode_q;
    pms_pkg::pms_mode_t mode_d;

    wire logic we_pll = wr && (addr == `PMS_PLL_CONTROL_REGISTER_OFS);
    wire logic we_vr  = wr && (addr == `PMS_REG_CTL_OFS);
    wire logic we_req = wr && (addr == `PMS_MODE_REQ_OFS);

    // pll register is lost across hibernate, reloaded on wake
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pll_q <= `PMS_PLL_RST;
        else if (hw_reset_start)
            pll_q <= `PMS_PLL_RST;
        else if (we_pll)
            pll_q <= wdata[1:0];
    end

    // regulator register keeps its value through hibernate
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            vr_q <= `PMS_REG_RST;
        else if (we_vr)
            vr_q <= wdata[5:0];
    end

    wire logic pll_off = pll_q[`PMS_PLL_OFF_BIT];
    wire logic pll_byp = pll_q[`PMS_PLL_BYP_BIT];
    wire logic regulator_frequency_field_zero = (vr_q[`PMS_REGULATOR_FREQUENCY_FIELD_LSB +: 2] == 2'h0);

    // enabled wake sources, each gated by its own bit except rpin_s, which has none
    wire logic wk_phy = ~phy_n_s & vr_q[`PMS_WEN_PHY_BIT];
    wire logic wk_rtc = rtc_ev & vr_q[`PMS_WEN_RTC_BIT];
    wire logic wk_eth = eth_wake & vr_q[`PMS_WEN_ETH_BIT];
    wire logic hib_wake = wk_phy | wk_rtc | wk_eth | rpin_s;

    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    // requests take effect when the core goes idle; a request for
    // full-on or sleep with the pll off is ignored (software duty)
    logic [2:0] req_q;                        // pending request code
    logic       req_v_q;                      // request pending

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            req_q   <= `PMS_REQ_FULLON;
            req_v_q <= 1'b0;
        end
        else if (we_req)
        begin
            req_q   <= wdata[2:0];
            req_v_q <= 1'b1;
        end
        else if (core_idle || mode_q != pms_pkg::PMS_FULLON &&
                 mode_q != pms_pkg::PMS_ACTIVE)
            req_v_q <= 1'b0;
    end

    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            pms_pkg::PMS_FULLON, pms_pkg::PMS_ACTIVE:
            begin
                if (regulator_frequency_field_zero)
                    mode_d = pms_pkg::PMS_HIBER;
                else if (req_v_q && core_idle)
                begin
                    case (req_q)
                        `PMS_REQ_FULLON:
                            if (!pll_off)
                                mode_d = pms_pkg::PMS_FULLON;
                        `PMS_REQ_ACTIVE:
                            mode_d = pms_pkg::PMS_ACTIVE;
                        `PMS_REQ_SLEEP:
                            if (!pll_off)
                                mode_d = pms_pkg::PMS_SLEEP;
                        `PMS_REQ_DEEP:
                            mode_d = pms_pkg::PMS_DEEP;
                        default:
                            mode_d = mode_q;
                    endcase
                end
            end
            pms_pkg::PMS_SLEEP:
            begin
                // any wake event; bypass chooses the target, except rst_pin, which always goes to full-on
                if (rpin_s)
                    mode_d = pms_pkg::PMS_FULLON;
                else if (rtc_ev || ~phy_n_s || eth_wake)
                    mode_d = pll_byp ? pms_pkg::PMS_ACTIVE
                                     : pms_pkg::PMS_FULLON;
            end
            pms_pkg::PMS_DEEP:
            begin
                // only reset or rtc leave deep sleep
                if (rpin_s)
                    mode_d = pms_pkg::PMS_FULLON;
                else if (rtc_ev)
                    mode_d = pms_pkg::PMS_ACTIVE;
            end
            pms_pkg::PMS_HIBER:
            begin
                // the latched wake restarts through reset into full-on;
                // the event may be gone by the time software rewrites
                // the frequency, so the live source is not re-sampled
                if (wake_q && !regulator_frequency_field_zero)
                    mode_d = pms_pkg::PMS_FULLON;
            end
            default:
                mode_d = pms_pkg::PMS_FULLON;
        endcase
    end

    // mode register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mode_q <= pms_pkg::PMS_FULLON;
        else
            mode_q <= mode_d;
    end

    // ------------------------------------------------------------
    // wake output
    // ------------------------------------------------------------
    // writing zero frequency drops it; an enabled wake raises it and
    // software must then write a non-zero frequency to leave hibernate
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wake_q <= 1'b1;
        else if (mode_q == pms_pkg::PMS_HIBER && hib_wake)
            wake_q <= 1'b1;
        else if (we_vr && wdata[1:0] == 2'h0)
            wake_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // hibernate exit needs a non-zero frequency; in hardware the wake
    // output resets the register, here software must rewrite the frequency
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            core_clock_en           <= 1'b1;
            sys_clock_en            <= 1'b1;
            core_power_en           <= 1'b1;
            pads_hiz                <= 1'b0;
            l1_dma_block            <= 1'b0;
            async_block             <= 1'b0;
            hw_reset_start          <= 1'b0;
            sdram_self_refresh_hold <= 1'b0;
            regulator_wake_output   <= 1'b1;
            mode                    <= 5'h01;
        end
        else
        begin
            core_clock_en  <= (mode_d == pms_pkg::PMS_FULLON) ||
                              (mode_d == pms_pkg::PMS_ACTIVE);
            sys_clock_en   <= (mode_d != pms_pkg::PMS_DEEP) &&
                              (mode_d != pms_pkg::PMS_HIBER);
            core_power_en  <= (mode_d != pms_pkg::PMS_HIBER);
            pads_hiz       <= (mode_d == pms_pkg::PMS_HIBER);
            l1_dma_block   <= (mode_d == pms_pkg::PMS_SLEEP);
            async_block    <= (mode_d == pms_pkg::PMS_DEEP) ||
                              (mode_d == pms_pkg::PMS_HIBER);
            hw_reset_start <= (mode_q == pms_pkg::PMS_HIBER) &&
                              (mode_d == pms_pkg::PMS_FULLON);
            // held in hibernate and through the following reset pulse
            sdram_self_refresh_hold <= vr_q[`PMS_SELFREF_BIT] &&
                ((mode_d == pms_pkg::PMS_HIBER) ||
                 (mode_q == pms_pkg::PMS_HIBER));
            regulator_wake_output <= wake_q;
            mode           <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (rd)
        begin
            case (addr)
                `PMS_PLL_CONTROL_REGISTER_OFS:  rdata <= {6'h00, pll_q};
                `PMS_REG_CTL_OFS:  rdata <= {2'h0, vr_q};
                `PMS_MODE_REQ_OFS: rdata <= {4'h0, req_v_q, req_q};
                `PMS_STATUS_OFS:   rdata <= {2'h0, wake_q, mode_q};
                default:           rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_deep_rtc;
        @(posedge clk) disable iff (rst)
        (mode_q == pms_pkg::PMS_DEEP && !rpin_s && rtc_ev)
            |=> mode_q == pms_pkg::PMS_ACTIVE;
    endproperty
    a_deep_rtc: assert property (p_deep_rtc)
        else $error("rtc wake from deep sleep not active");

    property p_deep_rst;
        @(posedge clk) disable iff (rst)
        (mode_q == pms_pkg::PMS_DEEP && rpin_s)
            |=> mode_q == pms_pkg::PMS_FULLON;
    endproperty
    a_deep_rst: assert property (p_deep_rst)
        else $error("reset in deep sleep not full-on");

    property p_deep_hold;
        @(posedge clk) disable iff (rst)
        (mode_q == pms_pkg::PMS_DEEP && !rpin_s && !rtc_ev)
            |=> mode_q == pms_pkg::PMS_DEEP;
    endproperty
    a_deep_hold: assert property (p_deep_hold)
        else $error("deep sleep left without cause");

    property p_sleep_clk;
        @(posedge clk) disable iff (rst)
        mode_q == pms_pkg::PMS_SLEEP |-> !core_clock_en && sys_clock_en;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk)
        else $error("sleep clock gating wrong");

    property p_sleep_wake;
        @(posedge clk) disable iff (rst)
        (mode_q == pms_pkg::PMS_SLEEP && !rpin_s && rtc_ev && pll_byp)
            |=> mode_q == pms_pkg::PMS_ACTIVE;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("bypass wake not active");

    property p_deep_clk;
        @(posedge clk) disable iff (rst)
        mode_q == pms_pkg::PMS_DEEP |-> !sys_clock_en && async_block;
    endproperty
    a_deep_clk: assert property (p_deep_clk)
        else $error("deep sleep clocks running");

    property p_hib_pads;
        @(posedge clk) disable iff (rst)
        mode_q == pms_pkg::PMS_HIBER |-> pads_hiz && !core_power_en;
    endproperty
    a_hib_pads: assert property (p_hib_pads)
        else $error("hibernate pads or supply wrong");

    property p_hib_reset;
        @(posedge clk) disable iff (rst)
        (mode_q == pms_pkg::PMS_HIBER && mode_d == pms_pkg::PMS_FULLON)
            |=> hw_reset_start ##1 !hw_reset_start;
    endproperty
    a_hib_reset: assert property (p_hib_reset)
        else $error("hibernate wake without reset pulse");

    property p_regulator_frequency_field_low;
        @(posedge clk) disable iff (rst)
        (we_vr && wdata[1:0] == 2'h0 && mode_q != pms_pkg::PMS_HIBER)
            |=> ##1 !regulator_wake_output;
    endproperty
    a_regulator_frequency_field_low: assert property (p_regulator_frequency_field_low)
        else $error("wake output not dropped");

endmodule // pms_sequencer
`default_nettype wire

// ---- pms_far_side.sv ----
/*
 behavioural far side of the power mode sequencer: phy wake pin with a
 pull-up, an rtc event source and the external core regulator.
 assumes the bench clock and that the bench requests every wake event.
*/
`timescale 1ns/100ps
`default_nettype none

module pms_far_side
#(
    parameter int RAMP = 3                 // regulator ramp, larger = slower
)
(
    input  wire logic clk,                 // bench clock
    input  wire logic phy_req,             // bench asks for the pin pull
    input  wire logic rtc_req,             // rising edge = one rtc event
    input  wire logic regulator_wake_output, // wake line from the block
    output var  logic wake_pin_n,          // pin with pull-up
    output var  logic rtc_wake,            // rtc event level
    output var  logic supply_on            // core rail is up
);
    logic [3:0] rtc_cnt_q = 4'h0;          // length of the rtc event
    logic       rtc_req_q = 1'b0;          // edge detect of the request
    logic [3:0] ramp_q    = 4'h0;          // regulator ramp timer
    logic       supply_q  = 1'b0;          // rail state

    // -----------------------------------------------------------
    // wake pin: any device may pull it low, pull-up otherwise
    // -----------------------------------------------------------
    assign wake_pin_n = ~phy_req;

    // rtc event is a short level so the block's synchroniser sees it
    always_ff @(posedge clk)
    begin
        rtc_req_q <= rtc_req;
        if (rtc_req && !rtc_req_q)
            rtc_cnt_q <= 4'h4;
        else if (rtc_cnt_q != 4'h0)
            rtc_cnt_q <= rtc_cnt_q - 4'h1;
    end
    assign rtc_wake = (rtc_cnt_q != 4'h0);

    // regulator drops at once when told, ramps up slowly on wake
    always_ff @(posedge clk)
    begin
        if (!regulator_wake_output)
        begin
            ramp_q   <= 4'h0;
            supply_q <= 1'b0;
        end
        else if (ramp_q != RAMP[3:0])
            ramp_q <= ramp_q + 4'h1;
        else
            supply_q <= 1'b1;
    end
    assign supply_on = supply_q;
endmodule // pms_far_side

`default_nettype wire

// ---- tb_top.sv ----
/*
 self-checking bench of the power mode sequencer: one task a scenario.
 assumes pms_pkg, pms_regs.svh, pms_sequencer and pms_far_side.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pms_regs.svh"

module tb_top;
    logic       clk = 1'b0;                // 100 MHz bench clock
    logic       rst, wr, rd, rst_pin, eth_wake, core_idle, phy_req, rtc_req;
    logic [7:0] addr, wdata, rdata;        // register port
    logic       wake_pin_n, rtc_wake, core_clock_en, sys_clock_en;
    logic       core_power_en, regulator_wake_output, pads_hiz;
    logic       l1_dma_block, async_block, hw_reset_start;
    logic       sdram_self_refresh_hold, supply_on;
    logic [4:0] mode;                      // one-hot mode
    int         err_count = 0;             // mismatches
    int         checked = 0;               // comparisons
    int         cycles = 0;                // watchdog on a hang
    int         kicks = 0;                 // reset kicks seen

    pms_sequencer pms_sequencer_inst (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .wake_pin_n(wake_pin_n), .rtc_wake(rtc_wake), .rst_pin(rst_pin),
        .eth_wake(eth_wake), .core_idle(core_idle),
        .core_clock_en(core_clock_en), .sys_clock_en(sys_clock_en),
        .core_power_en(core_power_en),
        .regulator_wake_output(regulator_wake_output),
        .pads_hiz(pads_hiz), .l1_dma_block(l1_dma_block),
        .async_block(async_block), .hw_reset_start(hw_reset_start),
        .sdram_self_refresh_hold(sdram_self_refresh_hold), .mode(mode));

    pms_far_side pms_far_side_inst (.clk(clk), .phy_req(phy_req),
        .rtc_req(rtc_req), .regulator_wake_output(regulator_wake_output),
        .wake_pin_n(wake_pin_n), .rtc_wake(rtc_wake), .supply_on(supply_on));

    // -----------------------------------------------------------
    // clock, watchdog and reset-kick counter
    // -----------------------------------------------------------
    initial
    begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (hw_reset_start === 1'b1)
            kicks++;
        if (cycles == 5000)
        begin
            err_count++;
            wrap_up();
        end
    end

    // -----------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask

    // bounded wait: a stuck mode shows as a mismatch, not a hang
    task automatic wait_mode(input pms_pkg::pms_mode_t m);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            #1;
            if (mode === m)
                break;
        end
        check({3'h0, mode}, {3'h0, m});
    endtask

    task automatic go_mode(input logic [2:0] c, input pms_pkg::pms_mode_t m);
        wr_reg(`PMS_MODE_REQ_OFS, {5'h0, c});
        core_idle <= 1'b1;
        wait_mode(m);
        core_idle <= 1'b0;
    endtask

    task automatic rtc_pulse();
        @(posedge clk);
        rtc_req <= 1'b1;
        @(posedge clk);
        rtc_req <= 1'b0;
    endtask

    task automatic fire(input int s);
        if (s == 0)
            phy_req <= 1'b1;
        else if (s == 1)
            rtc_pulse();
        else
            eth_wake <= 1'b1;
    endtask

    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_reset();
        check({3'h0, mode}, {3'h0, pms_pkg::PMS_FULLON});
        check({6'h0, core_clock_en, sys_clock_en}, 8'h03);
        check({6'h0, core_power_en, pads_hiz}, 8'h02);
        rd_chk(`PMS_PLL_CONTROL_REGISTER_OFS, 8'h00);
        wr_reg(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        rd_chk(`PMS_REG_CTL_OFS, 8'h03);
        rd_chk(`PMS_STATUS_OFS, 8'h21);
    endtask

    task automatic t_sleep();
        go_mode(`PMS_REQ_SLEEP, pms_pkg::PMS_SLEEP);
        check({6'h0, core_clock_en, sys_clock_en}, 8'h01);
        check({7'h0, l1_dma_block}, 8'h01);
        rtc_pulse();
        wait_mode(pms_pkg::PMS_FULLON);
        check({7'h0, l1_dma_block}, 8'h00);
        wr_reg(`PMS_PLL_CONTROL_REGISTER_OFS, 8'h02);
        go_mode(`PMS_REQ_SLEEP, pms_pkg::PMS_SLEEP);
        rtc_pulse();
        wait_mode(pms_pkg::PMS_ACTIVE);
        // pll off in active, then a sleep request must be dropped
        wr_reg(`PMS_PLL_CONTROL_REGISTER_OFS, 8'h01);
        wr_reg(`PMS_MODE_REQ_OFS, {5'h0, `PMS_REQ_SLEEP});
        core_idle <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check({3'h0, mode}, {3'h0, pms_pkg::PMS_ACTIVE});
        core_idle <= 1'b0;
        wr_reg(`PMS_PLL_CONTROL_REGISTER_OFS, 8'h00);
        go_mode(`PMS_REQ_FULLON, pms_pkg::PMS_FULLON);
    endtask

    task automatic t_deep();
        go_mode(`PMS_REQ_DEEP, pms_pkg::PMS_DEEP);
        check({6'h0, core_clock_en, sys_clock_en}, 8'h00);
        check({7'h0, async_block}, 8'h01);
        eth_wake <= 1'b1;
        phy_req  <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check({3'h0, mode}, {3'h0, pms_pkg::PMS_DEEP});
        eth_wake <= 1'b0;
        phy_req  <= 1'b0;
        rtc_pulse();
        wait_mode(pms_pkg::PMS_ACTIVE);
        check({7'h0, async_block}, 8'h00);
        go_mode(`PMS_REQ_DEEP, pms_pkg::PMS_DEEP);
        rst_pin <= 1'b1;
        wait_mode(pms_pkg::PMS_FULLON);
        rst_pin <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // enter hibernate, try a disabled source, then wake on the enabled one
    task automatic t_hiber(input logic [7:0] en, input int s, input int d);
        int k;
        wr_reg(`PMS_PLL_CONTROL_REGISTER_OFS, 8'h02);
        wr_reg(`PMS_REG_CTL_OFS, en);
        wait_mode(pms_pkg::PMS_HIBER);
        check({7'h0, regulator_wake_output}, 8'h00);
        check({5'h0, core_power_en, core_clock_en, sys_clock_en}, 8'h00);
        check({7'h0, pads_hiz}, 8'h01);
        check({7'h0, sdram_self_refresh_hold}, {7'h0, en[5]});
        fire(d);
        repeat (8) @(posedge clk);
        #1 check({6'h0, regulator_wake_output, supply_on}, 8'h00);
        phy_req  <= 1'b0;
        eth_wake <= 1'b0;
        k = kicks;
        fire(s);
        for (int i = 0; i < 10 && regulator_wake_output !== 1'b1; i++)
            @(posedge clk);
        #1 check({7'h0, regulator_wake_output}, 8'h01);
        phy_req  <= 1'b0;
        eth_wake <= 1'b0;
        wr_reg(`PMS_REG_CTL_OFS, en | 8'h03);
        wait_mode(pms_pkg::PMS_FULLON);
        check({7'h0, sdram_self_refresh_hold}, {7'h0, en[5]});
        rd_chk(`PMS_PLL_CONTROL_REGISTER_OFS, 8'h00);
        rd_chk(`PMS_REG_CTL_OFS, en | 8'h03);
        // the kick is counted at the edge after it launches
        check(8'(kicks - k), 8'h01);
        check({7'h0, sdram_self_refresh_hold}, 8'h00);
    endtask

    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        {wr, rd, rst_pin, eth_wake, core_idle, phy_req, rtc_req} = 7'h00;
        addr  = 8'h00;
        wdata = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1 t_reset();
        t_sleep();
        t_deep();
        t_hiber(8'h24, 0, 1);
        t_hiber(8'h08, 1, 2);
        t_hiber(8'h10, 2, 0);
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
